// ---- verilog/iowdt_top.sv ----
// watchdog timer controlled by two write-only I/O ports
`timescale 1ns/1ps
// Overview of operation
// - a write to the arm port enables and restarts the countdown
// - a write to the disarm port stops the watchdog, no expiry until rearmed
// - the data written to the disarm port is ignored
// - arm value F gives 0 s, each step down adds 8 s, 0 gives 120 s
// - reset or NMI action is chosen by the jumper, never by software
// - on timeout the selected action is asserted
// - jumper default selects system reset
// - clear-watchdog input clears an asserted NMI condition
module iowdt_top #(
    parameter int SEC_CYCLES = iowdt_pkg::SEC_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clkEn,
    input  wire logic        ioWrite,
    input  wire logic [15:0] ioAddr,
    input  wire logic [15:0] ioData,
    input  wire logic        expiryActionJumper,
    input  wire logic        clearWatchdog,
    output logic             wdtReset,
    output logic             wdtNmi,
    output logic             wdtArmed
);
    // ------------------------------------------------------------------
    // port decode
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [15:0] a, input logic [15:0] p);
        hit = (a == p);
    endfunction

    logic armWr;
    logic disarmWr;
    logic [3:0] selVal;
    // only the address matters for disarm; data is never looked at
    assign armWr    = ioWrite && hit(ioAddr, iowdt_pkg::ARM_PORT);
    assign disarmWr = ioWrite && hit(ioAddr, iowdt_pkg::DISARM_PORT);
    assign selVal   = ioData[iowdt_pkg::TIMEOUT_LSB +: iowdt_pkg::TIMEOUT_W];

    // ------------------------------------------------------------------
    // countdown state
    // ------------------------------------------------------------------
    iowdt_pkg::iowdt_state_e state_r, state_nxt;
    logic [31:0] tick_r, tick_nxt;
    logic [6:0]  secLeft_r, secLeft_nxt;
    logic        nmi_r, nmi_nxt;
    logic        rst_r, rst_nxt;
    logic        expire;

    // expiry only when no arm or disarm write lands on the same edge: a kick or a
    // disarm that races the last tick must win, or software could lose
    assign expire = (state_r == iowdt_pkg::IOWDT_COUNT)
                    && (secLeft_r == iowdt_pkg::SEC_ZERO)
                    && !armWr && !disarmWr;

    // next values; one address is decoded per cycle, so arm and disarm
    // never meet
    always_comb
    begin
        state_nxt   = state_r;
        tick_nxt    = tick_r;
        secLeft_nxt = secLeft_r;
        // NMI is held until cleared; a set in the same cycle wins
        nmi_nxt     = (nmi_r && !clearWatchdog)
                      || (expire && expiryActionJumper);
        // reset is a one-cycle pulse; jumper low (default) means reset
        rst_nxt     = expire && !expiryActionJumper;
        case (state_r)
            iowdt_pkg::IOWDT_COUNT:
            begin
                if (secLeft_r == iowdt_pkg::SEC_ZERO)
                begin
                    if (expire)
                        state_nxt = iowdt_pkg::IOWDT_FIRED;
                end
                else if (tick_r == 32'(SEC_CYCLES - 1))
                begin
                    tick_nxt    = '0;
                    secLeft_nxt = secLeft_r - 7'h01;
                end
                else
                    tick_nxt = tick_r + 32'h1;
            end
            iowdt_pkg::IOWDT_IDLE,
            iowdt_pkg::IOWDT_FIRED:
                state_nxt = state_r;
            default:
                state_nxt = iowdt_pkg::IOWDT_IDLE;
        endcase
        if (armWr)
        begin
            // rearm restarts the full interval, so refresh kicks land here
            state_nxt   = iowdt_pkg::IOWDT_COUNT;
            tick_nxt    = '0;
            // F->0 s, 0->120 s
            secLeft_nxt = 7'((iowdt_pkg::TIMEOUT_MAXV - selVal)
                          * iowdt_pkg::STEP_SEC);
        end
        else if (disarmWr)
        begin
            state_nxt   = iowdt_pkg::IOWDT_IDLE;
            tick_nxt    = '0;
            secLeft_nxt = secLeft_r;
        end
    end

    // registers; clkEn freezes everything, but a low rst_n still clears them
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_r   <= iowdt_pkg::IOWDT_IDLE;
            tick_r    <= '0;
            secLeft_r <= iowdt_pkg::SEC_ZERO;
            nmi_r     <= 1'b0;
            rst_r     <= 1'b0;
        end
        else if (clkEn)
        begin
            state_r   <= state_nxt;
            tick_r    <= tick_nxt;
            secLeft_r <= secLeft_nxt;
            nmi_r     <= nmi_nxt;
            rst_r     <= rst_nxt;
        end
    end

    assign wdtReset = rst_r;
    assign wdtNmi   = nmi_r;
    assign wdtArmed = (state_r == iowdt_pkg::IOWDT_COUNT);

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_armStarts;
        @(posedge clk) disable iff (!rst_n)
        (clkEn && armWr) |=> wdtArmed;
    endproperty
    a_armStarts: assert property (p_armStarts)
        else $error("arm write did not start countdown");

    property p_disarmStops;
        @(posedge clk) disable iff (!rst_n)
        (clkEn && disarmWr && !armWr) |=>
            !wdtArmed && !$rose(wdtReset) && !$rose(wdtNmi);
    endproperty
    a_disarmStops: assert property (p_disarmStops)
        else $error("disarm write did not stop watchdog");

    property p_disarmAnyData;
        @(posedge clk) disable iff (!rst_n)
        (clkEn && disarmWr) |=> secLeft_r == $past(secLeft_r);
    endproperty
    a_disarmAnyData: assert property (p_disarmAnyData)
        else $error("disarm data changed timeout");

    property p_decode;
        @(posedge clk) disable iff (!rst_n)
        (clkEn && armWr) |=>
            secLeft_r == 7'((4'hF - $past(selVal)) * 8);
    endproperty
    a_decode: assert property (p_decode)
        else $error("timeout decode wrong");

    sequence s_expire;
        clkEn && wdtArmed && secLeft_r == 7'h00 && !armWr && !disarmWr;
    endsequence
    property p_nmiAction;
        @(posedge clk) disable iff (!rst_n)
        (s_expire and expiryActionJumper) |=> wdtNmi && !wdtReset;
    endproperty
    a_nmiAction: assert property (p_nmiAction)
        else $error("nmi not raised on expiry");

    property p_resetAction;
        @(posedge clk) disable iff (!rst_n)
        (s_expire and !expiryActionJumper) |=>
            (wdtReset && !$rose(wdtNmi)) ##1 !wdtReset;
    endproperty
    a_resetAction: assert property (p_resetAction)
        else $error("reset not asserted on expiry");

    property p_noEarly;
        @(posedge clk) disable iff (!rst_n)
        $rose(wdtReset) || $rose(wdtNmi) |-> $past(secLeft_r) == 7'h00;
    endproperty
    a_noEarly: assert property (p_noEarly)
        else $error("action before countdown end");

    property p_nmiClear;
        @(posedge clk) disable iff (!rst_n)
        (clkEn && wdtNmi && clearWatchdog
            && !(expire && expiryActionJumper)) |=> !wdtNmi;
    endproperty
    a_nmiClear: assert property (p_nmiClear)
        else $error("nmi not cleared");

    property p_nmiHeld;
        @(posedge clk) disable iff (!rst_n)
        (clkEn && wdtNmi && !clearWatchdog) |=> wdtNmi;
    endproperty
    a_nmiHeld: assert property (p_nmiHeld)
        else $error("nmi dropped without clear");

    // nothing can fire unless a countdown was running the cycle before
    property p_quietDisarmed;
        @(posedge clk) disable iff (!rst_n)
        !wdtArmed |=> !$rose(wdtReset) && !$rose(wdtNmi);
    endproperty
    a_quietDisarmed: assert property (p_quietDisarmed)
        else $error("action while not armed");

    // a low clock enable must hold every piece of state
    property p_freeze;
        @(posedge clk) disable iff (!rst_n)
        !clkEn |=> $stable(state_r) && $stable(tick_r)
            && $stable(secLeft_r) && $stable(wdtNmi) && $stable(wdtReset);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved while clock enable low");

    property p_tickBound;
        @(posedge clk) disable iff (!rst_n)
        tick_r < 32'(SEC_CYCLES);
    endproperty
    a_tickBound: assert property (p_tickBound)
        else $error("second counter ran past its end");

    property p_resetIdle;
        @(posedge clk) !rst_n |=> !wdtArmed && !wdtReset && !wdtNmi;
    endproperty
    a_resetIdle: assert property (p_resetIdle)
        else $error("not idle after reset");
endmodule // iowdt_top

// ---- verilog/iowdt_pkg.sv ----
// constants for the I/O port watchdog timer
package iowdt_pkg;
    // ------------------------------------------------------------------
    // port addresses and data
    // ------------------------------------------------------------------
    localparam logic [15:0] DISARM_PORT  = 16'h0441;
    localparam logic [15:0] ARM_PORT     = 16'h0443;
    localparam int          TIMEOUT_LSB  = 0;
    localparam int          TIMEOUT_W    = 4;
    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int          CLK_HZ       = 50000000;
    localparam int          STEP_SEC     = 8;
    localparam int          SEC_CYCLES   = CLK_HZ;
    localparam logic [3:0]  TIMEOUT_MAXV = 4'hF;
    localparam logic [6:0]  SEC_ZERO     = 7'h00;
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        IOWDT_IDLE  = 2'b00,
        IOWDT_COUNT = 2'b01,
        IOWDT_FIRED = 2'b11
    } iowdt_state_e;
endpackage

// ---- sim/iowdt_host.sv ----
// host model issuing I/O port writes to the watchdog
`timescale 1ns/1ps
module iowdt_host (
    input  wire logic        clk,
    output logic             ioWrite,
    output logic [15:0]      ioAddr,
    output logic [15:0]      ioData
);
    initial
    begin
        ioWrite = 1'b0;
        ioAddr  = 16'h0000;
        ioData  = 16'h0000;
    end
    // one-cycle write strobe; a released bus shows scrambled values
    task automatic portWrite(input logic [15:0] a, input logic [15:0] d);
        @(negedge clk);
        ioWrite = 1'b1;
        ioAddr  = a;
        ioData  = d;
        @(negedge clk);
        ioWrite = 1'b0;
        ioAddr  = ~a;
        ioData  = ~d;
    endtask
endmodule // iowdt_host

// ---- sim/io_port_watchdog_timer_tb.sv ----
// self-checking bench for the I/O port watchdog timer
`timescale 1ns/1ps
module io_port_watchdog_timer_tb;
    localparam int SEC = 10;  // short second keeps the run brief
    logic clk, rst_n, clkEn, jumper, clearWd;
    logic ioWrite, wdtReset, wdtNmi, wdtArmed;
    logic [15:0] ioAddr, ioData;
    int errCount, checkCount, fires, f0, n, t;
    iowdt_host iowdt_host_inst (.clk(clk), .ioWrite(ioWrite),
        .ioAddr(ioAddr), .ioData(ioData));
    iowdt_top #(.SEC_CYCLES(SEC)) iowdt_top_inst (.clk(clk), .rst_n(rst_n),
        .clkEn(clkEn), .ioWrite(ioWrite), .ioAddr(ioAddr), .ioData(ioData),
        .expiryActionJumper(jumper), .clearWatchdog(clearWd),
        .wdtReset(wdtReset), .wdtNmi(wdtNmi), .wdtArmed(wdtArmed));
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // count expiry actions so quiet windows can be checked
    always @(posedge clk)
        if (wdtReset === 1'b1 || wdtNmi === 1'b1) fires++;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp)
        begin
            errCount++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic results();
        if (errCount == 0 && checkCount > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // cycles from the write edge to an expiry action, bounded
    task automatic waitFire(output int c);
        c = 0;
        while (!(wdtReset === 1'b1 || wdtNmi === 1'b1))
        begin
            @(posedge clk);
            #1;
            c++;
            if (c > 1300)
            begin
                errCount++;
                results();
            end
        end
    endtask
    task automatic arm(input logic [3:0] v);
        iowdt_host_inst.portWrite(iowdt_pkg::ARM_PORT, {12'hA5C, v});
    endtask
    initial
    begin
        rst_n = 1'b0;
        clkEn = 1'b1;
        jumper = 1'b0;
        clearWd = 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        check({wdtReset, wdtNmi, wdtArmed}, 0);
        // every timeout code, with the default reset action
        for (int v = 15; v >= 0; v--)
        begin
            arm(v[3:0]);
            waitFire(n);
            t = (15 - v) * iowdt_pkg::STEP_SEC * SEC;
            check(n, t + 1);
            check({wdtReset, wdtNmi}, 2'h2);
            @(posedge clk);
            #1;
            check({wdtReset, wdtArmed}, 0);
        end
        // disarm with either data pattern stops the count
        for (int i = 0; i < 2; i++)
        begin
            arm(4'hE);
            repeat (10) @(posedge clk);
            #1;
            check(wdtArmed, 1);
            f0 = fires;
            iowdt_host_inst.portWrite(iowdt_pkg::DISARM_PORT,
                i ? 16'hFFFF : 16'h0000);
            repeat (100) @(posedge clk);
            #1;
            check(wdtArmed, 0);
            check(fires - f0, 0);
        end
        // unmapped address and a frozen clock enable are ignored
        iowdt_host_inst.portWrite(16'h0442, 16'h000F);
        clkEn = 1'b0;
        arm(4'hF);
        clkEn = 1'b1;
        repeat (10) @(posedge clk);
        #1;
        check(wdtArmed, 0);
        check(fires - f0, 0);
        // a low clock enable holds a running countdown past its end
        arm(4'hE);
        @(negedge clk) clkEn = 1'b0;
        repeat (100) @(negedge clk);
        clkEn = 1'b1;
        check(wdtArmed, 1);
        check(fires - f0, 0);
        // refresh before expiry restarts the countdown
        arm(4'hE);
        repeat (60) @(posedge clk);
        f0 = fires;
        arm(4'hE);
        repeat (70) @(posedge clk);
        #1;
        check(fires - f0, 0);
        waitFire(n);
        check(n, iowdt_pkg::STEP_SEC * SEC + 1 - 70);
        // jumper picks a held NMI, which stays set until the clear input drops it
        @(negedge clk) jumper = 1'b1;
        arm(4'hF);
        waitFire(n);
        repeat (5) @(posedge clk);
        #1;
        check({wdtReset, wdtNmi}, 2'h1);
        @(negedge clk) clearWd = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check(wdtNmi, 0);
        @(negedge clk) clearWd = 1'b0;
        // reset in mid-run drops a held NMI and a running count
        arm(4'hF);
        waitFire(n);
        @(negedge clk) rst_n = 1'b0;
        @(negedge clk) rst_n = 1'b1;
        check({wdtReset, wdtNmi, wdtArmed}, 0);
        arm(4'hE);
        repeat (10) @(negedge clk);
        rst_n = 1'b0;
        @(negedge clk) rst_n = 1'b1;
        f0 = fires;
        repeat (100) @(posedge clk);
        #1;
        check(wdtArmed, 0);
        check(fires - f0, 0);
        results();
    end
endmodule // io_port_watchdog_timer_tb
